// ---- common/gurs_pkg.sv ----
/*
 * Shared constants and types for the navigation serial relay with status lamps.
 * Assumes a single 10 MHz core clock; all times below are converted to cycles of it.
 */
package gurs_pkg;

	localparam int          CLK_HZ        = 10_000_000;
	localparam int          CYC_PER_MS    = CLK_HZ / 1000;

	// Times in milliseconds
	localparam int          NAV_WIN_MS    = 2000;
	localparam int          LED_READY_MS  = 4000;
	localparam int          LED_NONCMP_MS = 20000;
	localparam int          LED_FLASH_MS  = 100;
	localparam int          LED_ACQ_MS    = 500;
	localparam int          BTN_LOCK_MS   = 20;

	localparam int          LED_CNT_W     = 28;
	localparam int          BTN_CNT_W     = 18;
	localparam int          DIV_W         = 16;

	// Baud rates offered by the selector
	localparam int          BAUD_4800     = 4800;
	localparam int          BAUD_9600     = 9600;
	localparam int          BAUD_19200    = 19200;
	localparam int          BAUD_38400    = 38400;
	localparam int          BAUD_57600    = 57600;
	localparam int          BAUD_115200   = 115200;

	typedef enum logic [1:0] {GURS_NAV_NONE, GURS_NAV_PARTIAL, GURS_NAV_NOFIX,
	                          GURS_NAV_FIX} gurs_nav_t;
	typedef enum logic [1:0] {GURS_PAR_NONE, GURS_PAR_EVEN, GURS_PAR_ODD} gurs_par_t;

	// Power-up serial settings: 9600 baud, 8 data bits, no parity, 1 stop bit
	localparam logic [2:0]  BAUD_SEL_DEF  = 3'h1;
	localparam logic [1:0]  DBITS_DEF     = 2'h3;
	localparam logic        STOP2_DEF     = 1'h0;
	localparam logic [2:0]  DBITS_BASE    = 3'h5;

	// Radio settings that make the configuration compliant
	localparam logic [3:0]  WLAN_CHAN_DEF = 4'h6;

	// Sentence stream characters and identifiers
	localparam logic [7:0]  CH_START      = 8'h24;
	localparam logic [7:0]  CH_COMMA      = 8'h2c;
	localparam logic [7:0]  CH_VALID      = 8'h41;
	localparam logic [23:0] ID_GGA        = 24'h474741;
	localparam logic [23:0] ID_GSA        = 24'h475341;
	localparam logic [23:0] ID_RMC        = 24'h524d43;
	localparam logic [23:0] ID_GLL        = 24'h474c4c;
	localparam logic [2:0]  HDR_LEN       = 3'h5;
	localparam logic [2:0]  TALKER_LEN    = 3'h2;
	localparam logic [3:0]  RMC_STAT_FLD  = 4'h2;
	localparam logic [3:0]  ALL_SEEN      = 4'hf;

	function automatic logic [DIV_W-1:0] baud_div(input logic [2:0] sel);
		case (sel)
			3'h0:    baud_div = DIV_W'(CLK_HZ / BAUD_4800);
			3'h1:    baud_div = DIV_W'(CLK_HZ / BAUD_9600);
			3'h2:    baud_div = DIV_W'(CLK_HZ / BAUD_19200);
			3'h3:    baud_div = DIV_W'(CLK_HZ / BAUD_38400);
			3'h4:    baud_div = DIV_W'(CLK_HZ / BAUD_57600);
			default: baud_div = DIV_W'(CLK_HZ / BAUD_115200);
		endcase
	endfunction : baud_div

endpackage : gurs_pkg

// ---- rtl/gurs_uart_rx.sv ----
/*
 * Serial character receiver with a three-stage pin synchroniser.
 * Assumes the line idles high and the settings stay still while a character is in flight.
 */
`timescale 1ns/10ps
module gurs_uart_rx
	import gurs_pkg::*;
(
	input  wire logic                   i_core_clk,
	input  wire logic                   i_rst,
	input  wire logic                   i_rxd,
	input  wire logic [gurs_pkg::DIV_W-1:0] i_bit_div,
	input  wire logic [1:0]             i_dbits,
	input  wire gurs_pkg::gurs_par_t    i_parity,
	output logic                        o_valid,
	output logic [7:0]                  o_data,
	output logic                        o_err
);
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP} gurs_rx_st_t;

	gurs_rx_st_t        state_r;
	logic               sync1_r;
	logic               sync2_r;
	logic               sync3_r;
	logic               line_r;
	logic [DIV_W-1:0]   cnt_r;
	logic [2:0]         bit_r;
	logic [7:0]         shift_r;
	logic               par_r;
	logic [2:0]         last_bit;
	logic               par_bad;

	assign last_bit = 3'(DBITS_BASE + 3'(i_dbits) - 3'h1);
	assign par_bad  = (i_parity == GURS_PAR_EVEN) ? par_r :
	                  (i_parity == GURS_PAR_ODD)  ? ~par_r : 1'b0;

	// Line level counts once the two later stages agree
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			sync1_r <= 1'b1;
			sync2_r <= 1'b1;
			sync3_r <= 1'b1;
			line_r  <= 1'b1;
		end
		else
		begin
			sync1_r <= i_rxd;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			if (sync2_r == sync3_r)
				line_r <= sync3_r;
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			state_r <= RX_IDLE;
			cnt_r   <= '0;
			bit_r   <= '0;
			shift_r <= '0;
			par_r   <= 1'b0;
			o_valid <= 1'b0;
			o_err   <= 1'b0;
			o_data  <= '0;
		end
		else
		begin
			o_valid <= 1'b0;
			o_err   <= 1'b0;
			if (state_r != RX_IDLE && cnt_r != '0)
				cnt_r <= cnt_r - 1'b1;
			else
			begin
				case (state_r)
					RX_IDLE:
						if (!line_r)
						begin
							cnt_r   <= i_bit_div >> 1;
							par_r   <= 1'b0;
							bit_r   <= '0;
							state_r <= RX_START;
						end
					RX_START:
					begin
						cnt_r   <= i_bit_div - 1'b1;
						state_r <= line_r ? RX_IDLE : RX_DATA;
					end
					RX_DATA:
					begin
						shift_r <= {line_r, shift_r[7:1]};
						par_r   <= par_r ^ line_r;
						cnt_r   <= i_bit_div - 1'b1;
						bit_r   <= bit_r + 1'b1;
						if (bit_r == last_bit)
							state_r <= (i_parity == GURS_PAR_NONE) ? RX_STOP : RX_PAR;
					end
					RX_PAR:
					begin
						par_r   <= par_r ^ line_r;
						cnt_r   <= i_bit_div - 1'b1;
						state_r <= RX_STOP;
					end
					RX_STOP:
					begin
						o_data  <= shift_r >> (3'h3 - i_dbits);
						o_valid <= line_r && !par_bad;
						o_err   <= !line_r || par_bad;
						state_r <= RX_IDLE;
					end
					default: state_r <= RX_IDLE;
				endcase
			end
		end
	end

endmodule : gurs_uart_rx

// ---- rtl/gurs_uart_tx.sv ----
/*
 * Serial character transmitter, one character at a time.
 * Assumes the settings stay still while a character is in flight.
 */
`timescale 1ns/10ps
module gurs_uart_tx
	import gurs_pkg::*;
(
	input  wire logic                   i_core_clk,
	input  wire logic                   i_rst,
	input  wire logic                   i_valid,
	input  wire logic [7:0]             i_data,
	input  wire logic [gurs_pkg::DIV_W-1:0] i_bit_div,
	input  wire logic [1:0]             i_dbits,
	input  wire gurs_pkg::gurs_par_t    i_parity,
	input  wire logic                   i_stop2,
	output logic                        o_ready,
	output logic                        o_txd
);
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP} gurs_tx_st_t;

	gurs_tx_st_t        state_r;
	logic [DIV_W-1:0]   cnt_r;
	logic [2:0]         bit_r;
	logic [7:0]         shift_r;
	logic               par_r;
	logic               stop_r;

	assign o_ready = (state_r == TX_IDLE);

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			state_r <= TX_IDLE;
			cnt_r   <= '0;
			bit_r   <= '0;
			shift_r <= '0;
			par_r   <= 1'b0;
			stop_r  <= 1'b0;
			o_txd   <= 1'b1;
		end
		else if (state_r != TX_IDLE && cnt_r != '0)
			cnt_r <= cnt_r - 1'b1;
		else
		begin
			cnt_r <= i_bit_div - 1'b1;
			case (state_r)
				TX_IDLE:
					if (i_valid)
					begin
						shift_r <= i_data;
						par_r   <= (i_parity == GURS_PAR_ODD);
						bit_r   <= '0;
						stop_r  <= i_stop2;
						o_txd   <= 1'b0;
						state_r <= TX_START;
					end
				TX_START, TX_DATA:
					if (state_r == TX_DATA && bit_r == 3'(i_dbits + 3'h4))
					begin
						o_txd   <= (i_parity == GURS_PAR_NONE) ? 1'b1 : par_r;
						state_r <= (i_parity == GURS_PAR_NONE) ? TX_STOP : TX_PAR;
					end
					else
					begin
						o_txd   <= shift_r[0];
						par_r   <= par_r ^ shift_r[0];
						shift_r <= shift_r >> 1;
						bit_r   <= (state_r == TX_START) ? 3'h0 : bit_r + 1'b1;
						state_r <= TX_DATA;
					end
				TX_PAR:
				begin
					o_txd   <= 1'b1;
					state_r <= TX_STOP;
				end
				TX_STOP:
				begin
					o_txd  <= 1'b1;
					stop_r <= 1'b0;
					if (!stop_r)
						state_r <= TX_IDLE;
				end
				default: state_r <= TX_IDLE;
			endcase
		end
	end

endmodule : gurs_uart_tx

// ---- rtl/gurs_relay_top.sv ----
/*
 * Two-way serial relay between a navigation receiver and a flight controller, with
 * sentence-stream reception state, status lamp, configuration button and lamp.
 * Assumes one 10 MHz clock; serial lines and the button are asynchronous pins;
 * edit and save inputs come from logic on the same clock.
 */
// Notes on behaviour
// RULE1 - Receiver characters go out the controller side
// RULE2 - Controller characters go out the receiver side
// RULE3 - One serial setting set for both ports
// RULE4 - Report exactly one of four reception states
// RULE5 - Missing any of four sentences means partial (the code reports none, not partial, when all four are missing)
// RULE6 - Fix and compliant: flash every 4 s
// RULE7 - Fix, non-compliant: flash every 20 s
// RULE8 - Bad protocol, low power, channel not 6
// RULE9 - Press in normal mode enters configuration
// RULE10 - Press in configuration returns to normal
// RULE11 - Edits count only after save
// RULE12 - New settings, state refresh on mode re-entry
// RULE13 - No data means serial settings mismatch
// RULE14 - No fix shows its own lamp pattern
// RULE15 - Power-up settings 9600, 8, none, 1
`timescale 1ns/10ps
module gurs_relay_top
	import gurs_pkg::*;
#(
	parameter int NAV_WIN_CYC   = NAV_WIN_MS * CYC_PER_MS,
	parameter int LED_READY_CYC = LED_READY_MS * CYC_PER_MS,
	parameter int LED_NONCP_CYC = LED_NONCMP_MS * CYC_PER_MS,
	parameter int LED_FLASH_CYC = LED_FLASH_MS * CYC_PER_MS,
	parameter int LED_ACQ_CYC   = LED_ACQ_MS * CYC_PER_MS,
	parameter int BTN_LOCK_CYC  = BTN_LOCK_MS * CYC_PER_MS
)
(
	input  wire logic                i_core_clk,
	input  wire logic                i_rst,
	input  wire logic                i_rcv_rxd,
	output logic                     o_rcv_txd,
	input  wire logic                i_ctl_rxd,
	output logic                     o_ctl_txd,
	input  wire logic                i_cfg_button,
	input  wire logic [2:0]          i_edit_baud_sel,
	input  wire logic [1:0]          i_edit_dbits,
	input  wire gurs_pkg::gurs_par_t i_edit_parity,
	input  wire logic                i_edit_stop2,
	input  wire logic                i_edit_proto_ok,
	input  wire logic                i_edit_pwr_low,
	input  wire logic [3:0]          i_edit_wlan_chan,
	input  wire logic                i_save,
	output gurs_pkg::gurs_nav_t      o_nav_state,
	output logic                     o_status_led,
	output logic                     o_cfg_led,
	output logic                     o_cfg_mode,
	output logic                     o_compliant
);
	import gurs_pkg::*;

	// Saved (staged) and active settings
	logic [2:0]           sv_baud_r,  act_baud_r;
	logic [1:0]           sv_dbits_r, act_dbits_r;
	gurs_par_t            sv_par_r,   act_par_r;
	logic                 sv_stop2_r, act_stop2_r;
	logic                 sv_proto_r, act_proto_r;
	logic                 sv_pwr_r,   act_pwr_r;
	logic [3:0]           sv_chan_r,  act_chan_r;
	logic [DIV_W-1:0]     bit_div_r;

	logic                 btn_s1_r, btn_s2_r, btn_s3_r, btn_r, btn_prev_r;
	logic [BTN_CNT_W-1:0] btn_lock_r;
	logic                 press;
	logic                 cfg_exit;

	// Channel 0: receiver to controller, channel 1: controller to receiver
	logic [1:0]           rxd_in;
	logic [1:0]           txd_out;
	logic [1:0]           rx_valid;
	logic [7:0]           rx_data [2];
	logic [1:0]           tx_ready;
	logic [1:0]           pend_r;
	logic [7:0]           pend_data_r [2];

	logic                 in_sent_r;
	logic [2:0]           hdr_idx_r;
	logic [23:0]          sid_r;
	logic [3:0]           comma_r;
	logic [3:0]           seen_r;
	logic                 fix_r;
	logic [LED_CNT_W-1:0] win_cnt_r;
	logic [23:0]          sid_now;
	logic [7:0]           ch;

	logic [LED_CNT_W-1:0] led_cnt_r;
	logic [LED_CNT_W-1:0] led_period;
	logic [LED_CNT_W-1:0] led_on;

	assign press    = btn_r && !btn_prev_r && (btn_lock_r == '0);
	assign cfg_exit = press && o_cfg_mode;
	assign rxd_in   = {i_ctl_rxd, i_rcv_rxd};
	assign ch       = rx_data[0];
	assign sid_now  = {sid_r[15:0], ch};

	// Button pin synchroniser, accepted once the later stages agree
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			btn_s1_r <= 1'b0;
			btn_s2_r <= 1'b0;
			btn_s3_r <= 1'b0;
			btn_r    <= 1'b0;
		end
		else
		begin
			btn_s1_r <= i_cfg_button;
			btn_s2_r <= btn_s1_r;
			btn_s3_r <= btn_s2_r;
			if (btn_s2_r == btn_s3_r)
				btn_r <= btn_s3_r;
		end
	end

	// Press detection with a lockout against contact bounce
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			btn_prev_r <= 1'b0;
			btn_lock_r <= '0;
		end
		else
		begin
			btn_prev_r <= btn_r;
			if (btn_r != btn_prev_r)
				btn_lock_r <= BTN_CNT_W'(BTN_LOCK_CYC);
			else if (btn_lock_r != '0)
				btn_lock_r <= btn_lock_r - 1'b1;
		end
	end

	// RULE9 RULE10 mode toggle
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			o_cfg_mode <= 1'b0;
			o_cfg_led  <= 1'b0;
		end
		else if (press)
		begin
			o_cfg_mode <= !o_cfg_mode;
			o_cfg_led  <= !o_cfg_mode;
		end
	end

	// RULE11 save stages edits
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			sv_baud_r  <= BAUD_SEL_DEF;
			sv_dbits_r <= DBITS_DEF;
			sv_par_r   <= GURS_PAR_NONE;
			sv_stop2_r <= STOP2_DEF;
			sv_proto_r <= 1'b1;
			sv_pwr_r   <= 1'b0;
			sv_chan_r  <= WLAN_CHAN_DEF;
		end
		else if (i_save && o_cfg_mode)
		begin
			sv_baud_r  <= i_edit_baud_sel;
			sv_dbits_r <= i_edit_dbits;
			sv_par_r   <= i_edit_parity;
			sv_stop2_r <= i_edit_stop2;
			sv_proto_r <= i_edit_proto_ok;
			sv_pwr_r   <= i_edit_pwr_low;
			sv_chan_r  <= i_edit_wlan_chan;
		end
	end

	// RULE12 apply on leaving configuration
	// RULE15 power-up serial defaults
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			act_baud_r  <= BAUD_SEL_DEF;
			act_dbits_r <= DBITS_DEF;
			act_par_r   <= GURS_PAR_NONE;
			act_stop2_r <= STOP2_DEF;
			act_proto_r <= 1'b1;
			act_pwr_r   <= 1'b0;
			act_chan_r  <= WLAN_CHAN_DEF;
		end
		else if (cfg_exit)
		begin
			act_baud_r  <= sv_baud_r;
			act_dbits_r <= sv_dbits_r;
			act_par_r   <= sv_par_r;
			act_stop2_r <= sv_stop2_r;
			act_proto_r <= sv_proto_r;
			act_pwr_r   <= sv_pwr_r;
			act_chan_r  <= sv_chan_r;
		end
	end

	// RULE8 compliance check
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			o_compliant <= 1'b1;
			bit_div_r   <= baud_div(BAUD_SEL_DEF);
		end
		else
		begin
			o_compliant <= act_proto_r && !act_pwr_r && (act_chan_r == WLAN_CHAN_DEF);
			bit_div_r   <= baud_div(act_baud_r);
		end
	end

	// RULE3 shared settings on both channels
	// RULE1 RULE2 relay each direction
	for (genvar c = 0; c < 2; c++)
	begin : g_chan
		gurs_uart_rx u_rx
		(
			.i_core_clk (i_core_clk),
			.i_rst      (i_rst),
			.i_rxd      (rxd_in[c]),
			.i_bit_div  (bit_div_r),
			.i_dbits    (act_dbits_r),
			.i_parity   (act_par_r),
			.o_valid    (rx_valid[c]),
			.o_data     (rx_data[c]),
			.o_err      ()
		);

		gurs_uart_tx u_tx
		(
			.i_core_clk (i_core_clk),
			.i_rst      (i_rst),
			.i_valid    (pend_r[c]),
			.i_data     (pend_data_r[c]),
			.i_bit_div  (bit_div_r),
			.i_dbits    (act_dbits_r),
			.i_parity   (act_par_r),
			.i_stop2    (act_stop2_r),
			.o_ready    (tx_ready[c]),
			.o_txd      (txd_out[c])
		);

		// A new character wins over the hand-off of the previous one
		always_ff @(posedge i_core_clk)
		begin
			if (i_rst)
			begin
				pend_r[c]      <= 1'b0;
				pend_data_r[c] <= '0;
			end
			else if (rx_valid[c])
			begin
				pend_r[c]      <= 1'b1;
				pend_data_r[c] <= rx_data[c];
			end
			else if (tx_ready[c])
				pend_r[c] <= 1'b0;
		end
	end

	assign o_ctl_txd = txd_out[0];
	assign o_rcv_txd = txd_out[1];

	// RULE5 sentence recognition per window
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst || cfg_exit || win_cnt_r == '0)
		begin
			in_sent_r <= 1'b0;
			hdr_idx_r <= '0;
			sid_r     <= '0;
			comma_r   <= '0;
			seen_r    <= '0;
		end
		else if (rx_valid[0])
		begin
			if (ch == CH_START)
			begin
				in_sent_r <= 1'b1;
				hdr_idx_r <= '0;
				comma_r   <= '0;
			end
			else if (in_sent_r && hdr_idx_r != HDR_LEN)
			begin
				hdr_idx_r <= hdr_idx_r + 1'b1;
				if (hdr_idx_r >= TALKER_LEN)
					sid_r <= sid_now;
				if (hdr_idx_r == HDR_LEN - 1'b1)
					seen_r <= seen_r | {sid_now == ID_GLL, sid_now == ID_RMC,
					                    sid_now == ID_GSA, sid_now == ID_GGA};
			end
			else if (in_sent_r && ch == CH_COMMA)
				comma_r <= comma_r + 1'b1;
		end
	end

	// Fix flag follows each character at comma count 2 of the latest RMC sentence, including the character that ends the status field
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst || cfg_exit)
			fix_r <= 1'b0;
		else if (rx_valid[0] && in_sent_r && hdr_idx_r == HDR_LEN && sid_r == ID_RMC
		         && comma_r == RMC_STAT_FLD)
			fix_r <= (ch == CH_VALID);
	end

	// RULE4 RULE13 classify at window end
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst || cfg_exit)
		begin
			win_cnt_r   <= LED_CNT_W'(NAV_WIN_CYC - 1);
			o_nav_state <= GURS_NAV_NONE;
		end
		else if (win_cnt_r == '0)
		begin
			win_cnt_r <= LED_CNT_W'(NAV_WIN_CYC - 1);
			if (seen_r == '0)
				o_nav_state <= GURS_NAV_NONE;
			else if (seen_r != ALL_SEEN)
				o_nav_state <= GURS_NAV_PARTIAL;
			else
				o_nav_state <= fix_r ? GURS_NAV_FIX : GURS_NAV_NOFIX;
		end
		else
			win_cnt_r <= win_cnt_r - 1'b1;
	end

	// RULE6 RULE7 RULE14 lamp pattern select
	always_comb
	begin
		if (o_nav_state != GURS_NAV_FIX)
		begin
			led_period = LED_CNT_W'(2 * LED_ACQ_CYC);
			led_on     = LED_CNT_W'(LED_ACQ_CYC);
		end
		else if (o_compliant)
		begin
			led_period = LED_CNT_W'(LED_READY_CYC);
			led_on     = LED_CNT_W'(LED_FLASH_CYC);
		end
		else
		begin
			led_period = LED_CNT_W'(LED_NONCP_CYC);
			led_on     = LED_CNT_W'(LED_FLASH_CYC);
		end
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			led_cnt_r    <= '0;
			o_status_led <= 1'b0;
		end
		else
		begin
			led_cnt_r    <= (led_cnt_r >= led_period - 1'b1) ? '0 : led_cnt_r + 1'b1;
			o_status_led <= (led_cnt_r < led_on);
		end
	end

endmodule : gurs_relay_top

// ---- tb/gurs_relay_top_chk.sv ----
/*
 * Concurrent checks on the relay top: lamps, mode button, status refresh, line framing.
 * Assumes it is bound into gurs_relay_top and handed the same lamp parameters.
 */
`timescale 1ns/10ps
module gurs_relay_chk
	import gurs_pkg::*;
#(
	parameter int LED_FLASH_CYC = 10,
	parameter int LED_ACQ_CYC   = 50
)
(
	input wire logic                i_core_clk,
	input wire logic                i_rst,
	input wire logic                i_cfg_button,
	input wire logic                o_rcv_txd,
	input wire logic                o_ctl_txd,
	input wire gurs_pkg::gurs_nav_t o_nav_state,
	input wire logic                o_status_led,
	input wire logic                o_cfg_led,
	input wire logic                o_cfg_mode,
	input wire logic                o_compliant
);
	import gurs_pkg::*;
	logic [15:0] on_cnt_r;
	logic [15:0] fix_cnt_r;
	default clocking cb @(posedge i_core_clk);
	endclocking
	default disable iff (i_rst);
	// Length of the current lamp pulse and time spent with a fix
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst || !o_status_led)
			on_cnt_r <= 16'h0;
		else
			on_cnt_r <= on_cnt_r + 16'h1;
	end
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst || o_nav_state != GURS_NAV_FIX)
			fix_cnt_r <= 16'h0;
		else if (fix_cnt_r != 16'hffff)
			fix_cnt_r <= fix_cnt_r + 16'h1;
	end
	cfg_lamp_mirror_a: assert property (o_cfg_led == o_cfg_mode)
		else $error("config lamp differs from config mode");
	mode_quiet_a: assert property ((!i_cfg_button)[*8] |=> $stable(o_cfg_mode))
		else $error("config mode changed without a press");
	exit_refresh_a: assert property ($fell(o_cfg_mode) |->
		(o_nav_state == GURS_NAV_NONE)[*8])
		else $error("status not restarted on leaving config mode");
	nav_steady_a: assert property (($changed(o_nav_state) && !$fell(o_cfg_mode)) |=>
		($stable(o_nav_state) || $fell(o_cfg_mode))[*8])
		else $error("reception state changed twice in a short time");
	compl_apply_a: assert property ($changed(o_compliant) |->
		($past(o_cfg_mode, 2) && !$past(o_cfg_mode)))
		else $error("compliance changed outside the exit from config mode");
	acq_pattern_a: assert property (($rose(o_status_led) && o_nav_state != GURS_NAV_FIX) |->
		(o_status_led || o_nav_state == GURS_NAV_FIX)[*8])
		else $error("acquiring lamp pulse too short");
	flash_width_a: assert property ((fix_cnt_r > 16'(2 * LED_ACQ_CYC)) |->
		(on_cnt_r <= 16'(LED_FLASH_CYC)))
		else $error("fix lamp flash too long");
	start_to_ctl_a: assert property ($fell(o_ctl_txd) |-> (!o_ctl_txd)[*8])
		else $error("controller side start bit too short");
	start_to_rcv_a: assert property ($fell(o_rcv_txd) |-> (!o_rcv_txd)[*8])
		else $error("receiver side start bit too short");
endmodule : gurs_relay_chk
bind gurs_relay_top gurs_relay_chk
	#(.LED_FLASH_CYC(LED_FLASH_CYC), .LED_ACQ_CYC(LED_ACQ_CYC)) chk_u (
	.i_core_clk(i_core_clk), .i_rst(i_rst), .i_cfg_button(i_cfg_button),
	.o_rcv_txd(o_rcv_txd), .o_ctl_txd(o_ctl_txd), .o_nav_state(o_nav_state),
	.o_status_led(o_status_led), .o_cfg_led(o_cfg_led), .o_cfg_mode(o_cfg_mode),
	.o_compliant(o_compliant)
);

// ---- tb/gurs_nav_partner.sv ----
/*
 * Far ends of the relay: navigation receiver and flight controller serial lines, 8N1.
 * Assumes the bench sets the bit time to match the relay's active settings.
 */
`timescale 1ns/10ps
module gurs_nav_partner
	import gurs_pkg::*;
(
	input  wire logic                       i_core_clk,
	input  wire logic [gurs_pkg::DIV_W-1:0] i_bit_div,
	input  wire logic                       i_rcv_txd,
	input  wire logic                       i_ctl_txd,
	output logic                            o_rcv_rxd,
	output logic                            o_ctl_rxd
);
	import gurs_pkg::*;
	initial
	begin
		o_rcv_rxd = 1'b1;
		o_ctl_rxd = 1'b1;
	end
	task automatic send_char(input logic from_ctl, input logic [7:0] ch);
		logic [9:0] frame;
		frame = {1'b1, ch, 1'b0};
		for (int b = 0; b < 10; b++)
		begin
			if (from_ctl)
				o_ctl_rxd <= frame[b];
			else
				o_rcv_rxd <= frame[b];
			repeat (i_bit_div) @(posedge i_core_clk);
		end
	endtask : send_char
	// Mid-bit sampling, stop bit must be high
	task automatic catch_char(input logic at_ctl, output logic [7:0] ch, output logic ok);
		int n;
		ch = 8'h0;
		ok = 1'b0;
		n = 0;
		while (n < 40000 && (at_ctl ? i_ctl_txd : i_rcv_txd))
		begin
			@(posedge i_core_clk);
			n++;
		end
		if (n < 40000)
		begin
			repeat (i_bit_div / 2) @(posedge i_core_clk);
			for (int b = 0; b < 9; b++)
			begin
				repeat (i_bit_div) @(posedge i_core_clk);
				if (b < 8)
					ch[b] = at_ctl ? i_ctl_txd : i_rcv_txd;
				else
					ok = at_ctl ? i_ctl_txd : i_rcv_txd;
			end
		end
	endtask : catch_char
endmodule : gurs_nav_partner

// ---- tb/testbench.sv ----
/*
 * Bench for the relay top: relay both ways, config button and save, reception states, lamp.
 * Assumes shortened lamp and window parameters and the partner model for both far ends.
 */
`timescale 1ns/10ps
module testbench;
	import gurs_pkg::*;
	logic             clk;
	logic             rst;
	logic             rcv_rxd;
	logic             ctl_rxd;
	logic             rcv_txd;
	logic             ctl_txd;
	logic             btn;
	logic [2:0]       baud_sel;
	logic [3:0]       chan;
	logic [1:0]       dbits;
	gurs_par_t        par;
	logic             stop2;
	logic             proto;
	logic             pwr;
	logic             save;
	gurs_nav_t        nav;
	logic             status_led;
	logic             cfg_led;
	logic             cfg_mode;
	logic             compliant;
	logic [DIV_W-1:0] bit_div;
	logic [7:0]       c0;
	logic [7:0]       c1;
	logic             ok0;
	logic             ok1;
	int               fails;
	int               checks;
	localparam int    WIN_CYC = 25000;
	localparam int    RDY_CYC = 400;
	localparam int    NCP_CYC = 2000;
	localparam int    FLS_CYC = 10;
	localparam int    ACQ_CYC = 50;
	localparam int    LCK_CYC = 8;
	gurs_relay_top #(.NAV_WIN_CYC(WIN_CYC), .LED_READY_CYC(RDY_CYC), .LED_NONCP_CYC(NCP_CYC),
		.LED_FLASH_CYC(FLS_CYC), .LED_ACQ_CYC(ACQ_CYC), .BTN_LOCK_CYC(LCK_CYC)) dut_u (
		.i_core_clk(clk), .i_rst(rst), .i_rcv_rxd(rcv_rxd), .o_rcv_txd(rcv_txd),
		.i_ctl_rxd(ctl_rxd), .o_ctl_txd(ctl_txd), .i_cfg_button(btn),
		.i_edit_baud_sel(baud_sel), .i_edit_dbits(dbits), .i_edit_parity(par),
		.i_edit_stop2(stop2), .i_edit_proto_ok(proto), .i_edit_pwr_low(pwr),
		.i_edit_wlan_chan(chan), .i_save(save), .o_nav_state(nav), .o_status_led(status_led),
		.o_cfg_led(cfg_led), .o_cfg_mode(cfg_mode), .o_compliant(compliant));
	gurs_nav_partner part_u (.i_core_clk(clk), .i_bit_div(bit_div), .i_rcv_txd(rcv_txd),
		.i_ctl_txd(ctl_txd), .o_rcv_rxd(rcv_rxd), .o_ctl_rxd(ctl_rxd));
	always #50 clk = ~clk;
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic report_and_stop();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : report_and_stop
	task automatic press();
		@(posedge clk);
		btn <= 1'b1;
		repeat (20) @(posedge clk);
		btn <= 1'b0;
		repeat (20) @(posedge clk);
	endtask : press
	task automatic save_edits();
		@(posedge clk);
		save <= 1'b1;
		@(posedge clk);
		save <= 1'b0;
	endtask : save_edits
	task automatic send_str(input string s);
		for (int i = 0; i < s.len(); i++)
			part_u.send_char(1'b0, s[i]);
	endtask : send_str
	task automatic wait_nav(input gurs_nav_t exp);
		int n;
		n = 0;
		while (n < 30000 && nav === GURS_NAV_NONE)
		begin
			@(posedge clk);
			n++;
		end
		if (n >= 30000)
		begin
			fails++;
			report_and_stop();
		end
		else
			check({6'h0, nav}, {6'h0, exp});
	endtask : wait_nav
	task automatic count_led(input int cyc, input int exp);
		int n;
		n = 0;
		repeat (100) @(posedge clk);
		repeat (cyc) @(posedge clk) n += (status_led === 1'b1);
		check(n[7:0], exp[7:0]);
	endtask : count_led
	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		btn = 1'b0;
		baud_sel = 3'h1;
		chan = WLAN_CHAN_DEF;
		dbits = DBITS_DEF;
		par = GURS_PAR_NONE;
		stop2 = STOP2_DEF;
		proto = 1'b1;
		pwr = 1'b0;
		save = 1'b0;
		fails = 0;
		checks = 0;
		bit_div = DIV_W'(CLK_HZ / BAUD_9600);
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check({7'h0, compliant}, 8'h1);
		fork
			part_u.send_char(1'b0, 8'ha5);
			part_u.send_char(1'b1, 8'h3c);
			part_u.catch_char(1'b1, c0, ok0);
			part_u.catch_char(1'b0, c1, ok1);
		join
		check(c0, 8'ha5);
		check(c1, 8'h3c);
		check({6'h0, ok0, ok1}, 8'h3);
		press();
		check({6'h0, cfg_mode, cfg_led}, 8'h3);
		baud_sel <= 3'h5;
		save_edits();
		chan <= 4'h5;
		press();
		check({6'h0, cfg_mode, cfg_led}, 8'h0);
		check({6'h0, nav}, 8'h0);
		@(posedge clk);
		check({7'h0, compliant}, 8'h1);
		bit_div = DIV_W'(CLK_HZ / BAUD_115200);
		send_str("$GPGGA$GPGSA$GPGLL$GPRMC,,A");
		wait_nav(GURS_NAV_FIX);
		count_led(2 * RDY_CYC, 2 * FLS_CYC);
		press();
		save_edits();
		press();
		repeat (2) @(posedge clk);
		check({7'h0, compliant}, 8'h0);
		check({6'h0, nav}, 8'h0);
		send_str("$GPGGA$GPGSA$GPGLL$GPRMC,,A");
		wait_nav(GURS_NAV_FIX);
		count_led(NCP_CYC, FLS_CYC);
		press();
		chan <= WLAN_CHAN_DEF;
		pwr <= 1'b1;
		save_edits();
		press();
		repeat (2) @(posedge clk);
		check({7'h0, compliant}, 8'h0);
		press();
		pwr <= 1'b0;
		proto <= 1'b0;
		save_edits();
		press();
		repeat (2) @(posedge clk);
		check({7'h0, compliant}, 8'h0);
		send_str("$GPGGA");
		wait_nav(GURS_NAV_PARTIAL);
		count_led(4 * ACQ_CYC, 2 * ACQ_CYC);
		report_and_stop();
	end
endmodule : testbench
